// [src/pbsp_pkg.sv]
/*
 * pbsp_pkg: constants and carrier types of the pipelined burst memory port.
 * assumes: all synchronous pins are driven from logic on clk_in.
 */
package pbsp_pkg;

    // memory geometry: four byte lanes, each eight data bits and one parity
    localparam int PBSP_ADDR_W = 21;
    localparam int PBSP_LANES = 4;
    localparam int PBSP_LANE_W = 8;
    localparam int PBSP_DATA_W = PBSP_LANES * PBSP_LANE_W;
    localparam int PBSP_SLOT_W = PBSP_LANE_W + 1;
    localparam int PBSP_WORD_W = PBSP_LANES * PBSP_SLOT_W;
    localparam int PBSP_BURST_W = 2;
    localparam int PBSP_FIFO_DEPTH = 32;
    localparam int PBSP_SYNC_W = 3;

    // positions inside the synchroniser vector
    localparam int PBSP_SYNC_OE = 0;
    localparam int PBSP_SYNC_SLEEP = 1;
    localparam int PBSP_SYNC_ORDER = 2;

    // reset values
    localparam logic [PBSP_BURST_W-1:0] PBSP_BEAT_RST = 2'h0;
    localparam logic [PBSP_LANES-1:0] PBSP_MASK_ALL = 4'hf;
    localparam logic [PBSP_LANES-1:0] PBSP_MASK_NONE = 4'h0;
    // drive off, sleep low (pull-down), strap high (pull-up)
    localparam logic [PBSP_SYNC_W-1:0] PBSP_SYNC_RST = 3'h5;

    // burst engine states, one-hot
    typedef enum logic [2:0] {
        PBSP_ST_IDLE = 3'h1,
        PBSP_ST_BURST = 3'h2,
        PBSP_ST_SLEEP = 3'h4
    } pbsp_state_e;

    // one clock's worth of registered synchronous pins
    typedef struct packed {
        logic [PBSP_ADDR_W-1:0] addr;
        logic [PBSP_DATA_W-1:0] data;
        logic [PBSP_LANES-1:0] parity;
        logic global_write_n;
        logic byte_write_enable_n;
        logic [PBSP_LANES-1:0] byte_lane_select_n;
        logic chip_select_a_n;
        logic chip_select_b;
        logic chip_select_c_n;
        logic burst_step_n;
        logic proc_addr_strobe_n;
        logic ctrl_addr_strobe_n;
    } pbsp_pins_s;

    // one queued write
    typedef struct packed {
        logic [PBSP_ADDR_W-1:0] addr;
        logic [PBSP_WORD_W-1:0] word;
        logic [PBSP_LANES-1:0] mask;
    } pbsp_wr_s;

endpackage : pbsp_pkg

// [src/pbsp_fifo.sv]
/*
 * pbsp_fifo: synchronous valid/ready fifo, width and depth as parameters.
 * assumes: one clock, active-low asynchronous reset, depth a power of two.
 */
`timescale 1ns/1ps

module pbsp_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);

    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0] count_reg;
    logic push;
    logic pop;

    // handshakes on both sides
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign in_ready_out = (count_reg != DEPTH[PTR_W:0]);
    assign out_valid_out = (count_reg != '0);
    assign out_data_out = mem_reg[rd_ptr_reg];

    // storage
    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data_in;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule : pbsp_fifo

// [src/pbsp_sram_port.sv]
/*
 * pbsp_sram_port: host port and storage of a pipelined burst static memory.
 * assumes: the controller drives all synchronous pins from clk_in; the
 * output-drive, sleep and burst-order pins are asynchronous and synced here.
 */
// Function
// - global write low on an edge writes all byte lanes, ignoring lane controls
// - byte writes happen only with byte write enable sampled low
// - each lane select writes its lane only when byte write enable is low
// - every synchronous input is registered on the rising clock edge; the code holds data and parity instead while the pins drive
// - step low advances the burst counter, otherwise the burst address holds
// - selected only when select a low, select b high, select c low
// - chip selects are looked at only on edges that load an address
// - a strobe low captures the address and loads its two low bits
// - with both strobes low, only the processor strobe acts
// - processor strobe ignored while select a is high; controller strobe not
// - output drive low makes data pins drive, high makes them inputs
// - first read clock after a deselected state keeps outputs undriven
// - write data and parity are captured in a data register on the edge; the code keeps the old data while the pins drive
// - read data is that of the address taken at the previous edge
// - sleep high stops activity while keeping stored contents
// - sleep low or open means normal operation
// - burst order strap low gives linear, high or open interleaved order
// - burst counter is two bits, wraps, and gives four beats
`timescale 1ns/1ps

module pbsp_sram_port
    import pbsp_pkg::*;
#(
    parameter int FIFO_DEPTH = PBSP_FIFO_DEPTH
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [PBSP_ADDR_W-1:0] addr_in,
    input wire logic [PBSP_DATA_W-1:0] dq_in,
    input wire logic [PBSP_LANES-1:0] parity_io_in,
    input wire logic global_write_n_in,
    input wire logic byte_write_enable_n_in,
    input wire logic [PBSP_LANES-1:0] byte_lane_select_n_in,
    input wire logic chip_select_a_n_in,
    input wire logic chip_select_b_in,
    input wire logic chip_select_c_n_in,
    input wire logic burst_step_n_in,
    input wire logic proc_addr_strobe_n_in,
    input wire logic ctrl_addr_strobe_n_in,
    input wire logic output_drive_n_in,
    input wire logic sleep_request_in,
    input wire logic burst_order_in,
    output logic [PBSP_DATA_W-1:0] dq_out,
    output logic [PBSP_LANES-1:0] parity_io_out,
    output logic dq_oe_n_out,
    output logic write_ready_out,
    output logic sleep_state_out
);

    // burst address generator: linear adds, interleaved exclusive-ors
    function automatic logic [PBSP_BURST_W-1:0] burst_lo(
        input logic [PBSP_BURST_W-1:0] start,
        input logic [PBSP_BURST_W-1:0] beat,
        input logic linear
    );
        logic [PBSP_BURST_W-1:0] lo;
        lo = linear ? (start + beat) : (start ^ beat);
        return lo;
    endfunction : burst_lo

    // lane mask from the write controls
    function automatic logic [PBSP_LANES-1:0] lane_mask(
        input pbsp_pins_s p
    );
        logic [PBSP_LANES-1:0] m;
        m = PBSP_MASK_NONE;
        if (!p.global_write_n)
        begin
            m = PBSP_MASK_ALL;
        end
        else if (!p.byte_write_enable_n)
        begin
            m = ~p.byte_lane_select_n;
        end
        return m;
    endfunction : lane_mask

    pbsp_pins_s pins_reg, pins_next;
    pbsp_state_e state_reg, state_next;
    logic [PBSP_SYNC_W-1:0] sync1_reg, sync2_reg;
    logic [1:0] order_wait_reg;
    logic order_taken_reg, linear_reg;
    logic [PBSP_ADDR_W-1:0] base_reg, eff_addr;
    logic [PBSP_BURST_W-1:0] start_reg, beat_reg, beat_next;
    logic [PBSP_WORD_W-1:0] mem_reg [0:(1 << PBSP_ADDR_W)-1];
    logic [PBSP_WORD_W-1:0] rd_word_reg, wr_word;
    logic oe_n_reg, write_ready_reg, sleep_reg;
    logic asleep, proc_ok, load, selected, access, do_write, do_read;
    logic [PBSP_LANES-1:0] wr_mask;
    pbsp_wr_s push_data, pop_data;
    logic push_ready, pop_valid;

    assign asleep = sync2_reg[PBSP_SYNC_SLEEP];

    // pin image; data kept while pins drive, so only input data is taken
    always_comb
    begin
        pins_next = '{
            addr: addr_in,
            data: dq_in,
            parity: parity_io_in,
            global_write_n: global_write_n_in,
            byte_write_enable_n: byte_write_enable_n_in,
            byte_lane_select_n: byte_lane_select_n_in,
            chip_select_a_n: chip_select_a_n_in,
            chip_select_b: chip_select_b_in,
            chip_select_c_n: chip_select_c_n_in,
            burst_step_n: burst_step_n_in,
            proc_addr_strobe_n: proc_addr_strobe_n_in,
            ctrl_addr_strobe_n: ctrl_addr_strobe_n_in
        };
        if (!oe_n_reg)
        begin
            pins_next.data = pins_reg.data;
            pins_next.parity = pins_reg.parity;
        end
    end

    // input register on every rising edge
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pins_reg <= '1; // all strobes idle high
        end
        else
        begin
            pins_reg <= pins_next;
        end
    end

    // two-flop synchroniser for output drive, sleep and order strap
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sync1_reg <= PBSP_SYNC_RST;
            sync2_reg <= PBSP_SYNC_RST;
        end
        else
        begin
            sync1_reg <= {burst_order_in, sleep_request_in, output_drive_n_in};
            sync2_reg <= sync1_reg;
        end
    end

    // order strap caught once the synchroniser holds the pin, not its reset
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            order_wait_reg <= '0;
            order_taken_reg <= 1'b0;
            linear_reg <= 1'b0;
        end
        else if (!order_taken_reg)
        begin
            order_wait_reg <= {order_wait_reg[0], 1'b1};
            order_taken_reg <= order_wait_reg[1];
            linear_reg <= !sync2_reg[PBSP_SYNC_ORDER];
        end
    end

    // strobe priority, selection and the address of this beat
    always_comb
    begin
        proc_ok = !pins_reg.proc_addr_strobe_n
            && !pins_reg.chip_select_a_n;
        load = proc_ok || !pins_reg.ctrl_addr_strobe_n;
        selected = load && !pins_reg.chip_select_a_n
            && pins_reg.chip_select_b
            && !pins_reg.chip_select_c_n;
        beat_next = beat_reg;
        if (state_reg == PBSP_ST_BURST && !pins_reg.burst_step_n)
        begin
            beat_next = beat_reg + 1'b1; // wraps at four
        end
        eff_addr = {base_reg[PBSP_ADDR_W-1:PBSP_BURST_W],
            burst_lo(start_reg, beat_next, linear_reg)};
        if (load)
        begin
            eff_addr = pins_reg.addr;
        end
        access = !asleep && (selected
            || (!load && state_reg == PBSP_ST_BURST));
        wr_mask = lane_mask(pins_reg);
        do_write = access && !(load && proc_ok)
            && (wr_mask != PBSP_MASK_NONE);
        do_read = access && !do_write;
    end

    // burst engine state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            PBSP_ST_IDLE:
            begin
                if (asleep)
                begin
                    state_next = PBSP_ST_SLEEP;
                end
                else if (selected)
                begin
                    state_next = PBSP_ST_BURST;
                end
            end
            PBSP_ST_BURST:
            begin
                if (asleep)
                begin
                    state_next = PBSP_ST_SLEEP;
                end
                else if (load && !selected)
                begin
                    state_next = PBSP_ST_IDLE; // deselect ends burst
                end
            end
            PBSP_ST_SLEEP:
            begin
                if (!asleep)
                begin
                    state_next = PBSP_ST_IDLE; // wake deselected
                end
            end
            default:
            begin
                state_next = PBSP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= PBSP_ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // burst address and counter
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            base_reg <= '0;
            start_reg <= PBSP_BEAT_RST;
            beat_reg <= PBSP_BEAT_RST;
        end
        else if (!asleep)
        begin
            if (selected)
            begin
                base_reg <= pins_reg.addr;
                start_reg <= pins_reg.addr[PBSP_BURST_W-1:0];
                beat_reg <= PBSP_BEAT_RST;
            end
            else if (!load)
            begin
                beat_reg <= beat_next;
            end
        end
    end

    // write word assembled lane by lane, parity above each byte
    genvar g;
    generate
        for (g = 0; g < PBSP_LANES; g = g + 1)
        begin : g_lane
            assign wr_word[g*PBSP_SLOT_W +: PBSP_SLOT_W] =
                {pins_reg.parity[g],
                 pins_reg.data[g*PBSP_LANE_W +: PBSP_LANE_W]};
            assign dq_out[g*PBSP_LANE_W +: PBSP_LANE_W] =
                rd_word_reg[g*PBSP_SLOT_W +: PBSP_LANE_W];
            assign parity_io_out[g] =
                rd_word_reg[g*PBSP_SLOT_W + PBSP_LANE_W];
        end
    endgenerate

    assign push_data = '{addr: eff_addr, word: wr_word, mask: wr_mask};

    // write queue between the pins and the array
    pbsp_fifo #(
        .WIDTH($bits(pbsp_wr_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .in_data_in(push_data),
        .in_valid_in(do_write),
        .in_ready_out(push_ready),
        .out_data_out(pop_data),
        .out_valid_out(pop_valid),
        .out_ready_in(!asleep)
    );

    // array write from the queue in one process, so the array has one writer
    always_ff @(posedge clk_in)
    begin
        for (int l = 0; l < PBSP_LANES; l++)
        begin
            if (pop_valid && !asleep && pop_data.mask[l])
            begin
                mem_reg[pop_data.addr][l*PBSP_SLOT_W +: PBSP_SLOT_W]
                    <= pop_data.word[l*PBSP_SLOT_W +: PBSP_SLOT_W];
            end
        end
    end

    // read pipeline stage
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rd_word_reg <= '0;
        end
        else if (do_read)
        begin
            rd_word_reg <= mem_reg[eff_addr];
        end
    end

    // pin direction, queue room and sleep flag
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            oe_n_reg <= 1'b1;
            write_ready_reg <= 1'b0;
            sleep_reg <= 1'b0;
        end
        else
        begin
            oe_n_reg <= sync2_reg[PBSP_SYNC_OE] || asleep
                || (do_read && load
                && state_reg != PBSP_ST_BURST);
            write_ready_reg <= push_ready;
            sleep_reg <= asleep;
        end
    end

    assign dq_oe_n_out = oe_n_reg;
    assign write_ready_out = write_ready_reg;
    assign sleep_state_out = sleep_reg;

endmodule : pbsp_sram_port

// [sim/pbsp_sram_port_sva.sv]
/* pbsp_sram_port_sva: port assertions of the burst memory port.
   assumes: bound to pbsp_sram_port; one clock, async low reset. */
`timescale 1ns/1ps

module pbsp_sram_port_sva
    import pbsp_pkg::*;
#(
    parameter int FIFO_DEPTH = PBSP_FIFO_DEPTH
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic global_write_n_in,
    input wire logic byte_write_enable_n_in,
    input wire logic chip_select_a_n_in,
    input wire logic chip_select_b_in,
    input wire logic chip_select_c_n_in,
    input wire logic burst_step_n_in,
    input wire logic proc_addr_strobe_n_in,
    input wire logic ctrl_addr_strobe_n_in,
    input wire logic output_drive_n_in,
    input wire logic sleep_request_in,
    input wire logic [PBSP_DATA_W-1:0] dq_out,
    input wire logic dq_oe_n_out,
    input wire logic write_ready_out,
    input wire logic sleep_state_out
);
    logic sel, live, desel, rd_go, pgate, no_wr;

    // decoded pin views
    assign sel = !chip_select_a_n_in && chip_select_b_in
        && !chip_select_c_n_in;
    assign live = !output_drive_n_in && !sleep_request_in;
    assign desel = !ctrl_addr_strobe_n_in && proc_addr_strobe_n_in && !sel;
    assign rd_go = !ctrl_addr_strobe_n_in && proc_addr_strobe_n_in && sel
        && global_write_n_in && byte_write_enable_n_in;
    assign pgate = !proc_addr_strobe_n_in && ctrl_addr_strobe_n_in
        && chip_select_a_n_in;
    assign no_wr = global_write_n_in && byte_write_enable_n_in
        && !sleep_request_in;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_sleep_enter: assert property (
        sleep_request_in [*5] |-> sleep_state_out)
        else $error("sleep state not entered");
    a_sleep_leave: assert property (
        !sleep_request_in [*5] |-> !sleep_state_out)
        else $error("sleep state without request");
    a_drive_float: assert property (
        output_drive_n_in [*5] |-> dq_oe_n_out)
        else $error("data pins driven while drive is off");
    a_first_float: assert property (
        live && desel ##1 live && rd_go |-> ##2 dq_oe_n_out)
        else $error("first read beat drove the pins");
    a_burst_drive: assert property (
        live && desel ##1 live && rd_go ##1 live && !burst_step_n_in
        && ctrl_addr_strobe_n_in && proc_addr_strobe_n_in
        |-> ##2 !dq_oe_n_out)
        else $error("second read beat not driven");
    a_proc_gated: assert property (
        desel ##1 pgate |-> ##2 $stable(dq_out))
        else $error("gated processor strobe acted");
    a_desel_hold: assert property (
        desel |-> ##2 $stable(dq_out))
        else $error("deselecting strobe started a read");
    a_queue_free: assert property (
        no_wr [*6] |-> write_ready_out)
        else $error("write queue not drained");
endmodule : pbsp_sram_port_sva

bind pbsp_sram_port pbsp_sram_port_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .global_write_n_in(global_write_n_in),
    .byte_write_enable_n_in(byte_write_enable_n_in),
    .chip_select_a_n_in(chip_select_a_n_in),
    .chip_select_b_in(chip_select_b_in),
    .chip_select_c_n_in(chip_select_c_n_in),
    .burst_step_n_in(burst_step_n_in),
    .proc_addr_strobe_n_in(proc_addr_strobe_n_in),
    .ctrl_addr_strobe_n_in(ctrl_addr_strobe_n_in),
    .output_drive_n_in(output_drive_n_in),
    .sleep_request_in(sleep_request_in),
    .dq_out(dq_out),
    .dq_oe_n_out(dq_oe_n_out),
    .write_ready_out(write_ready_out),
    .sleep_state_out(sleep_state_out)
);

// [sim/pbsp_ctrl_model.sv]
/* pbsp_ctrl_model: memory controller driving the port's pins.
   assumes: tasks called by the bench; pins change 1 ns after a rise. */
`timescale 1ns/1ps

module pbsp_ctrl_model
    import pbsp_pkg::*;
(
    input wire logic clk_in,
    output pbsp_pins_s pins_out,
    output logic drive_n_out,
    output logic sleep_out
);
    // idle pins at time zero
    initial
    begin
        pins_out = '1;
        drive_n_out = 1'b1;
        sleep_out = 1'b0;
    end

    // one pin cycle: k 0 idle, 1 ctrl, 2 proc, 3 both, 4 step
    task automatic cyc(input int k, input logic [2:0] s, input int a,
        input logic [1:0] w, input logic [3:0] ln);
        @(posedge clk_in);
        #1;
        pins_out.ctrl_addr_strobe_n = !(k == 1 || k == 3);
        pins_out.proc_addr_strobe_n = !(k == 2 || k == 3);
        pins_out.burst_step_n = k != 4;
        {pins_out.chip_select_a_n, pins_out.chip_select_b,
            pins_out.chip_select_c_n} = s;
        {pins_out.global_write_n, pins_out.byte_write_enable_n} = w;
        pins_out.byte_lane_select_n = ln;
        pins_out.addr = PBSP_ADDR_W'(a);
        // fresh write data, else a released bus that keeps toggling
        if (w != 2'h3)
            {pins_out.parity, pins_out.data} = 36'({$urandom, $urandom});
        else
            {pins_out.parity, pins_out.data} =
                ~{pins_out.parity, pins_out.data};
    endtask : cyc

    // output drive and sleep levels
    task automatic cfg(input logic od, input logic sl);
        @(posedge clk_in);
        #1;
        drive_n_out = od;
        sleep_out = sl;
    endtask : cfg
endmodule : pbsp_ctrl_model

// [sim/pbsp_sram_port_tb.sv]
/* pbsp_sram_port_tb: self-checking bench of the burst memory port.
   assumes: controller model drives the pins; reference memory kept here. */
`timescale 1ns/1ps

module pbsp_sram_port_tb
    import pbsp_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic burst_order_in = 1'b1;
    pbsp_pins_s pn;
    logic od_n, sl, oe_n, w_rdy, asleep;
    logic [PBSP_DATA_W-1:0] dq_out;
    logic [PBSP_LANES-1:0] par_out;
    logic [35:0] mem [int];
    int mismatches = 0;
    int checks_done = 0;
    int lin = 0;

    // 200 MHz clock
    always #2.5 clk_in = ~clk_in;

    pbsp_ctrl_model ctl (
        .clk_in(clk_in),
        .pins_out(pn),
        .drive_n_out(od_n),
        .sleep_out(sl)
    );

    // port with a short write queue
    pbsp_sram_port #(.FIFO_DEPTH(4)) DUT (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .addr_in(pn.addr),
        .dq_in(pn.data),
        .parity_io_in(pn.parity),
        .global_write_n_in(pn.global_write_n),
        .byte_write_enable_n_in(pn.byte_write_enable_n),
        .byte_lane_select_n_in(pn.byte_lane_select_n),
        .chip_select_a_n_in(pn.chip_select_a_n),
        .chip_select_b_in(pn.chip_select_b),
        .chip_select_c_n_in(pn.chip_select_c_n),
        .burst_step_n_in(pn.burst_step_n),
        .proc_addr_strobe_n_in(pn.proc_addr_strobe_n),
        .ctrl_addr_strobe_n_in(pn.ctrl_addr_strobe_n),
        .output_drive_n_in(od_n),
        .sleep_request_in(sl),
        .burst_order_in(burst_order_in),
        .dq_out(dq_out),
        .parity_io_out(par_out),
        .dq_oe_n_out(oe_n),
        .write_ready_out(w_rdy),
        .sleep_state_out(asleep)
    );

    // one counted comparison
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // counts, verdict, end of run
    task automatic conclude();
        $display("mismatches %0d checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    // reference write of the pins now presented
    function automatic void upd(input int a, input pbsp_pins_s p);
        logic [35:0] t;
        t = mem.exists(a) ? mem[a] : 'x;
        for (int g = 0; g < PBSP_LANES; g++)
            if (!p.global_write_n || (!p.byte_write_enable_n
                && !p.byte_lane_select_n[g]))
            begin
                t[8*g +: 8] = p.data[8*g +: 8];
                t[32+g] = p.parity[g];
            end
        mem[a] = t;
    endfunction : upd

    // controller strobe cycle, booked when it should write
    task automatic wr(input int a, input logic [2:0] s, input logic [1:0] w,
        input logic [3:0] ln, input bit hit);
        ctl.cyc(1, s, a, w, ln);
        if (hit)
            upd(a, pn);
    endtask : wr

    task automatic nap(input int n);
        repeat (n) ctl.cyc(0, 3'h2, 0, 2'h3, 4'hf);
    endtask : nap

    // deselect, read at a, five continuations with selects s
    task automatic burst(input int a, input logic [2:0] st,
        input logic [2:0] s);
        int bt;
        int ea;
        bt = 0;
        ctl.cyc(1, 3'h0, a ^ 4, 2'h3, 4'hf);
        for (int i = 0; i < 6; i++)
        begin
            if (i == 0)
                ctl.cyc(1, 3'h2, a, 2'h3, 4'hf);
            else
                ctl.cyc((i < 4 && st[(i-1)%3]) ? 4 : 0, s, a, 2'h3, 4'hf);
            if (i >= 2)
            begin
                ea = (a & ~3) | (lin ? ((a + bt) & 3) : ((a ^ bt) & 3));
                chk({par_out, dq_out}, mem[ea]);
                chk(36'(oe_n), 36'(i == 2));
                if (i < 5 && st[(i-2)%3])
                    bt++;
            end
        end
    endtask : burst

    // all scenarios under one burst order strap
    task automatic suite(input logic o);
        rst_n_in = 1'b0;
        burst_order_in = o;
        lin = (o == 1'b0);
        repeat (5) @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        nap(6);
        chk(36'(w_rdy), 36'h1);
        for (int a = 0; a < 24; a++)
            wr(a, 3'h2, {1'b0, 1'($urandom)}, 4'($urandom), 1);
        for (int a = 0; a < 8; a++)
            wr(a, 3'h2, {1'b1, 1'($urandom)}, 4'($urandom), 1);
        for (int k = 0; k < 8; k++)
            wr(16 + k, 3'(k), 2'h0, 4'hf, k == 2);
        wr(0, 3'h0, 2'h3, 4'hf, 0);
        ctl.cyc(2, 3'h6, 0, 2'h0, 4'hf);
        nap(1);
        ctl.cyc(3, 3'h2, 1, 2'h0, 4'hf);
        nap(4);
        ctl.cfg(1'b0, 1'b0);
        nap(4);
        burst(5, 3'h7, 3'h2);
        burst(10, 3'h2, 3'h0);
        for (int g = 0; g < 6; g++)
            burst(4 * g + 2'($urandom), 3'($urandom), 3'($urandom));
        // sleep refuses writes yet keeps contents
        ctl.cfg(1'b1, 1'b1);
        nap(6);
        chk(36'(asleep), 36'h1);
        wr(2, 3'h2, 2'h0, 4'hf, 0);
        ctl.cfg(1'b0, 1'b0);
        nap(6);
        chk(36'(asleep), 36'h0);
        burst(2, 3'h7, 3'h5);
        ctl.cfg(1'b1, 1'b0);
    endtask : suite

    // main sequence, second pass after a mid-run reset
    initial
    begin
        void'($urandom(57001));
        suite(1'b1);
        suite(1'b0);
        conclude();
    end

    // watchdog against a hung run
    initial
    begin
        #50000;
        mismatches++;
        conclude();
    end
endmodule : pbsp_sram_port_tb
